/* File: core/dq_vref_mode_register.sv */
/*
  Data input reference level mode register with two set point copies,
  written and read by mode register commands over a sampled link.
  Assumes the set point select bits come from a sibling register on the
  core clock and that the controller keeps its side of the protocol.
*/
// Overview of operation
// RULE_01: A read drives the eight register bits onto data lines 0 to 7.
// RULE_02: Reserved bit and unused data lines read as zero.
// RULE_03: Level write goes to set point 0 or 1 per write select.
// RULE_04: Bit 6 selects reference range 0 or range 1.
// RULE_05: Controller gives the range in the same write as the level.
// RULE_06: Values persist until overwritten or reset.
// RULE_07: Two copies per bit; reads and writes reach the write-selected copy.
// RULE_08: Operate select picks the copy that sets active level and range.
// RULE_09: Inactive copy ignored; writing it leaves operation undisturbed.
// RULE_10: Codes 0 to 50 valid; default code 29 in range 1.
// RULE_11: Controller never writes reserved codes and writes bit 7 as zero.
// RULE_12: Write select is bit 6, operate select bit 7; 0 means set point 0.
`timescale 1ns/1ns
module dq_vref_mode_register
  import ref_level_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ck_in,
  input wire logic cs_in,
  input wire logic cmd_write_in,
  input wire logic [5:0] ma_in,
  input wire logic [7:0] op_in,
  input wire logic setpoint_write_select_in,
  input wire logic setpoint_operate_select_in,
  output logic [15:0] dq_out,
  output logic dq_oe_n_out,
  output logic [5:0] level_code_out,
  output logic range_out
);
  link_sample_if cmd_if ();

  link_sampler u_link_sampler (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .ck_in(ck_in),
    .cs_in(cs_in),
    .cmd_write_in(cmd_write_in),
    .ma_in(ma_in),
    .op_in(op_in),
    .cmd_if(cmd_if)
  );

  // Register image as seen on the read data lines
  function automatic logic [15:0] read_image(input store_t s);
    read_image = {DQ_HIGH_ZERO, RESERVED_ZERO, s}; // RULE_01 RULE_02
  endfunction : read_image

  // Copy chosen by a set point select bit
  function automatic store_t pick_copy(input store_t c0, input store_t c1, input logic sel);
    pick_copy = sel ? c1 : c0; // RULE_12
  endfunction : pick_copy

  store_t copy_q [2];
  store_t copy_d [2];
  logic hit;
  logic wr_hit;
  logic rd_hit;

  // Command decode shared by the copy store and the read driver
  always_comb begin
    hit = cmd_if.cmd_valid && (cmd_if.cmd_addr == REG_ADDR);
    wr_hit = hit && cmd_if.cmd_write;
    rd_hit = hit && !cmd_if.cmd_write;
  end

  // Copy store: level and range land together in the write-selected copy.
  // Reserved level codes are kept as written; the controller avoids them.
  always_comb begin
    copy_d = copy_q;
    if (clk_en_in && wr_hit) begin
      copy_d[setpoint_write_select_in] = cmd_if.cmd_data[STORE_W-1:0]; // RULE_03 RULE_07 RULE_12 RULE_05
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      copy_q[0] <= STORE_RESET; // RULE_06 RULE_10
      copy_q[1] <= STORE_RESET; // RULE_06 RULE_10
    end else begin
      copy_q <= copy_d; // RULE_06
    end
  end

  logic [5:0] level_q, level_d;
  logic range_q, range_d;
  store_t active;

  // Active outputs follow the operate-selected copy only; the other copy
  // may be rewritten freely without moving the reference
  always_comb begin
    active = pick_copy(copy_q[0], copy_q[1], setpoint_operate_select_in); // RULE_08 RULE_09
    level_d = level_q;
    range_d = range_q;
    if (clk_en_in) begin
      level_d = active[LEVEL_MSB:LEVEL_LSB]; // RULE_08
      range_d = active[RANGE_BIT]; // RULE_04
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_q <= STORE_RESET[LEVEL_MSB:LEVEL_LSB]; // RULE_10
      range_q <= STORE_RESET[RANGE_BIT]; // RULE_10
    end else begin
      level_q <= level_d;
      range_q <= range_d;
    end
  end

  rd_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] dq_q, dq_d;
  logic oe_n_q, oe_n_d;
  store_t selected;

  // Read driver: one image per read, held for the drive time.
  // A read arriving while driving is dropped, so reads must be spaced.
  always_comb begin
    selected = pick_copy(copy_q[0], copy_q[1], setpoint_write_select_in); // RULE_07
    state_d = state_q;
    cnt_d = cnt_q;
    dq_d = dq_q;
    oe_n_d = oe_n_q;
    if (clk_en_in) begin
      case (state_q)
        RD_IDLE: begin
          if (rd_hit) begin
            dq_d = read_image(selected); // RULE_07 RULE_01
            oe_n_d = 1'b0;
            cnt_d = READ_DRIVE_CYCLES;
            state_d = RD_DRIVE;
          end
        end
        RD_DRIVE: begin
          if (cnt_q == CNT_ONE) begin
            dq_d = '0; // RULE_02
            oe_n_d = 1'b1;
            cnt_d = CNT_ZERO;
            state_d = RD_IDLE;
          end else begin
            cnt_d = cnt_q - CNT_ONE;
          end
        end
        default: begin
          dq_d = '0;
          oe_n_d = 1'b1;
          cnt_d = CNT_ZERO;
          state_d = RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= RD_IDLE;
      cnt_q <= CNT_ZERO;
      dq_q <= '0; // RULE_02
      oe_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dq_q <= dq_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign dq_out = dq_q;
  assign dq_oe_n_out = oe_n_q;
  assign level_code_out = level_q;
  assign range_out = range_q;
endmodule : dq_vref_mode_register

/* File: core/ref_level_pkg.sv */
/*
  Constants for the data reference level mode register: command address,
  field positions, reset value, read drive timing and read state encoding.
  Assumes a 100 MHz core clock and a sampled link clock of 80 ns period.
*/
package ref_level_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned READ_DRIVE_NS = 80;
  localparam int unsigned READ_DRIVE_CYCLES_INT =
    (READ_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] READ_DRIVE_CYCLES = READ_DRIVE_CYCLES_INT[3:0];
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  localparam logic [5:0] REG_ADDR = 6'h0e;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned OP_W = 8;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned LEVEL_LSB = 0;
  localparam int unsigned LEVEL_MSB = 5;
  localparam int unsigned RANGE_BIT = 6;
  localparam int unsigned STORE_W = 7;
  localparam logic [6:0] STORE_RESET = 7'h5d;
  localparam logic [7:0] DQ_HIGH_ZERO = 8'h00;
  localparam logic RESERVED_ZERO = 1'b0;
  localparam logic [5:0] LEVEL_MAX = 6'h32;

  typedef logic [6:0] store_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_DRIVE = 2'b01
  } rd_state_t;
endpackage : ref_level_pkg

/* File: core/link_sample_if.sv */
/*
  Carries one sampled mode register command from the link sampler to the
  register bank. Assumes both ends run on the core clock.
*/
`timescale 1ns/1ns
interface link_sample_if;
  logic cmd_valid;
  logic cmd_write;
  logic [5:0] cmd_addr;
  logic [7:0] cmd_data;
  modport src (output cmd_valid, output cmd_write, output cmd_addr, output cmd_data);
  modport dst (input cmd_valid, input cmd_write, input cmd_addr, input cmd_data);
endinterface : link_sample_if

/* File: core/link_sampler.sv */
/*
  Synchronises the link clock and command pins into the core clock and
  emits a one-cycle command pulse on each rising link clock edge with
  chip select high. Assumes pins are stable around link clock rising edges.
*/
`timescale 1ns/1ns
module link_sampler
  import ref_level_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ck_in,
  input wire logic cs_in,
  input wire logic cmd_write_in,
  input wire logic [5:0] ma_in,
  input wire logic [7:0] op_in,
  link_sample_if.src cmd_if
);
  localparam int unsigned PIN_W = 2 + ADDR_W + OP_W;
  logic [PIN_W:0] meta_q, meta_d, sync_q, sync_d;
  logic ck_prev_q, ck_prev_d;
  logic valid_q, valid_d, write_q, write_d;
  logic [5:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;

  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    ck_prev_d = ck_prev_q;
    valid_d = valid_q;
    write_d = write_q;
    addr_d = addr_q;
    data_d = data_q;
    if (clk_en_in) begin
      // Pulse lasts one enabled cycle; a frozen cycle keeps it pending
      valid_d = 1'b0;
      meta_d = {ck_in, cs_in, cmd_write_in, ma_in, op_in};
      sync_d = meta_q;
      ck_prev_d = sync_q[PIN_W];
      // Rising link clock edge with chip select
      if (sync_q[PIN_W] && !ck_prev_q && sync_q[PIN_W-1]) begin
        valid_d = 1'b1;
        write_d = sync_q[PIN_W-2];
        addr_d = sync_q[OP_W +: ADDR_W];
        data_d = sync_q[OP_W-1:0];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
      ck_prev_q <= 1'b0;
      valid_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      ck_prev_q <= ck_prev_d;
      valid_q <= valid_d;
      write_q <= write_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign cmd_if.cmd_valid = valid_q;
  assign cmd_if.cmd_write = write_q;
  assign cmd_if.cmd_addr = addr_q;
  assign cmd_if.cmd_data = data_q;
endmodule : link_sampler

/* File: verif/dq_vref_mode_register_assertions.sv */
/* Port checks for the reference level register; bound to its top module. */
`timescale 1ns/1ns
module dq_vref_mode_register_checker
  import ref_level_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ck_in,
  input wire logic cs_in,
  input wire logic cmd_write_in,
  input wire logic [5:0] ma_in,
  input wire logic [7:0] op_in,
  input wire logic setpoint_write_select_in,
  input wire logic setpoint_operate_select_in,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe_n_out,
  input wire logic [5:0] level_code_out,
  input wire logic range_out
);
  logic ck_q;
  logic [7:0] op_q;
  wire go = ck_in && !ck_q && cs_in;
  wire me = go && ma_in == REG_ADDR;
  wire eq = setpoint_write_select_in == setpoint_operate_select_in;
  wire [6:0] act = {range_out, level_code_out};
  always_ff @(posedge clock_in) ck_q <= ck_in;
  always_ff @(posedge clock_in) if (me) op_q <= op_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in || !clk_en_in);
  AST_RST: assert property ($rose(rst_n_in) |-> act == 7'h5d)
    else $error("reset level");
  AST_IDLE: assert property (dq_oe_n_out |-> dq_out == 16'h0000)
    else $error("idle data");
  AST_LEN: assert property ($fell(dq_oe_n_out) |-> !dq_oe_n_out [*8] ##1 dq_oe_n_out)
    else $error("drive length");
  AST_HOLD: assert property (!dq_oe_n_out && !$past(dq_oe_n_out) |-> $stable(dq_out))
    else $error("drive unstable");
  AST_RD: assert property (me && !cmd_write_in && dq_oe_n_out |-> ##[2:8] $fell(dq_oe_n_out))
    else $error("no read drive");
  AST_NODRV: assert property (go && (cmd_write_in || !me) && dq_oe_n_out |=> dq_oe_n_out [*8])
    else $error("stray drive");
  AST_ACT: assert property (me && cmd_write_in && eq |-> ##[3:8] act == op_q[6:0])
    else $error("active write");
  AST_INACT: assert property (me && cmd_write_in && !eq |=> $stable(act) [*8])
    else $error("inactive write");
  AST_FREEZE: assert property (disable iff (!rst_n_in) !clk_en_in |=>
    $stable(act) && $stable(dq_out) && $stable(dq_oe_n_out))
    else $error("frozen state moved");
endmodule : dq_vref_mode_register_checker
bind dq_vref_mode_register dq_vref_mode_register_checker chk_u (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .clk_en_in(clk_en_in),
  .ck_in(ck_in),
  .cs_in(cs_in),
  .cmd_write_in(cmd_write_in),
  .ma_in(ma_in),
  .op_in(op_in),
  .setpoint_write_select_in(setpoint_write_select_in),
  .setpoint_operate_select_in(setpoint_operate_select_in),
  .dq_out(dq_out),
  .dq_oe_n_out(dq_oe_n_out),
  .level_code_out(level_code_out),
  .range_out(range_out)
);

/* File: verif/link_ctrl_model.sv */
/* Controller model, one command per link clock pulse; clock still between. */
`timescale 1ns/1ns
module link_ctrl_model (
  output logic ck_out,
  output logic cs_out,
  output logic wr_out,
  output logic [5:0] ma_out,
  output logic [7:0] op_out
);
  initial {ck_out, cs_out, wr_out, ma_out, op_out} = 17'h00000;
  task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
    {cs_out, wr_out, ma_out, op_out} = {1'b1, w, a, d};
    #40 ck_out = 1'b1;
    #40 ck_out = 1'b0;
    // Released lines show the inverse
    {cs_out, wr_out, ma_out, op_out} = {1'b0, ~w, ~a, ~d};
    // Let a core clock edge pass before the next command
    #10;
  endtask : cmd
endmodule : link_ctrl_model

/* File: verif/dq_vref_mode_register_bench.sv */
/* Write and read table, unmapped read, second reset; uses the controller model. */
`timescale 1ns/1ns
module dq_vref_mode_register_bench;
  import ref_level_pkg::*;
  logic clock_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1;
  logic ws = 1'b0, os = 1'b0;
  logic ck_in, cs_in, cmd_write_in, dq_oe_n_out, range_out;
  logic [5:0] ma_in, level_code_out;
  logic [7:0] op_in;
  logic [15:0] dq_out;
  wire [15:0] act = {9'h000, range_out, level_code_out};
  store_t cp [2] = '{7'h5d, 7'h5d};
  // Write select, operate select, op bits 6:0
  logic [8:0] rows [4] = '{9'h032, 9'h140, 9'h180, 9'h05d};
  int n_mismatch = 0;
  int n_checks = 0;
  int k;
  always #5 clock_in = ~clock_in;
  link_ctrl_model ctrl_u (.ck_out(ck_in), .cs_out(cs_in), .wr_out(cmd_write_in),
    .ma_out(ma_in), .op_out(op_in));
  dq_vref_mode_register dut_u (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .ck_in(ck_in),
    .cs_in(cs_in),
    .cmd_write_in(cmd_write_in),
    .ma_in(ma_in),
    .op_in(op_in),
    .setpoint_write_select_in(ws),
    .setpoint_operate_select_in(os),
    .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out),
    .level_code_out(level_code_out),
    .range_out(range_out)
  );
  task complete_run;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick
  // Want ffff: no drive expected
  task rd(input logic [5:0] a, input logic [15:0] e);
    fork
      ctrl_u.cmd(1'b0, a, 8'h00);
      for (k = 0; k < 20 && dq_oe_n_out !== 1'b0; k++) tick(1);
    join
    chk(k < 20 ? dq_out : 16'hffff, e);
    if (k == 20 && e !== 16'hffff) complete_run();
    tick(12);
  endtask : rd
  initial begin
    tick(2);
    rst_n_in = 1'b1;
    tick(4);
    chk(act, 16'h005d);
    rd(REG_ADDR, 16'h005d);
    foreach (rows[i]) begin
      {ws, os} = rows[i][8:7];
      cp[rows[i][8]] = rows[i][6:0];
      ctrl_u.cmd(1'b1, REG_ADDR, {1'b0, rows[i][6:0]});
      rd(REG_ADDR, {9'h000, cp[ws]});
      chk(act, {9'h000, cp[os]});
    end
    for (int j = 0; j < 2; j++) begin
      ws = j[0];
      rd(REG_ADDR, {9'h000, cp[j]});
    end
    rd(6'h0d, 16'hffff);
    ctrl_u.cmd(1'b1, 6'h0d, 8'h2a);
    rd(REG_ADDR, {9'h000, cp[ws]});
    // Command during a clock-enable freeze is lost
    clk_en_in = 1'b0;
    ctrl_u.cmd(1'b1, REG_ADDR, 8'h22);
    tick(2);
    clk_en_in = 1'b1;
    tick(4);
    chk(act, {9'h000, cp[os]});
    rd(REG_ADDR, {9'h000, cp[ws]});
    rst_n_in = 1'b0;
    tick(2);
    rst_n_in = 1'b1;
    tick(4);
    chk(act, 16'h005d);
    ws = 1'b1;
    rd(REG_ADDR, 16'h005d);
    complete_run();
  end
endmodule : dq_vref_mode_register_bench
